// >>> rtl/csscfg_regs.svh
// Bit positions, encodings and timing figures of the clock source select control word
// Overview of operation
// - Muxes A, B, C primary decode ref/PLLA/PLLB/PLLC
// - C alternate select at bits 125:124, pin high
// - D primary select at bits 95:94, pin low
// - D alternate select at bits 127:126, pin high
// - Filter bit 0 short, 1 long time constant
// - Pump bit 0 low, 1 high current
// - Alternate-set pin picks primary or alternate set
`ifndef CSSCFG_REGS_SVH
`define CSSCFG_REGS_SVH
`define CSSCFG_WORD_W 128
`define CSSCFG_MUX_A_HI 23
`define CSSCFG_MUX_A_LO 22
`define CSSCFG_MUX_B_HI 47
`define CSSCFG_MUX_B_LO 46
`define CSSCFG_C_PRI_SRC_HI 71
`define CSSCFG_C_PRI_SRC_LO 70
`define CSSCFG_C_ALT_SRC_HI 125
`define CSSCFG_C_ALT_SRC_LO 124
`define CSSCFG_D_PRI_SRC_HI 95
`define CSSCFG_D_PRI_SRC_LO 94
`define CSSCFG_D_ALT_SRC_HI 127
`define CSSCFG_D_ALT_SRC_LO 126
`define CSSCFG_FILTER_A_BIT 20
`define CSSCFG_FILTER_B_BIT 44
`define CSSCFG_FILTER_C_PRI_BIT 68
`define CSSCFG_FILTER_C_ALT_BIT 92
`define CSSCFG_PUMP_A_BIT 19
`define CSSCFG_PUMP_B_BIT 43
`define CSSCFG_PUMP_C_PRI_BIT 67
`define CSSCFG_PUMP_C_ALT_BIT 91
`define CSSCFG_SHORT_TC_US 7
`define CSSCFG_LONG_TC_US 20
`define CSSCFG_LOW_PUMP_UA 2
`define CSSCFG_HIGH_PUMP_UA 10
`define CSSCFG_RESET_SRC 2'h0
`define CSSCFG_RESET_TC 1'b0
`define CSSCFG_RESET_PUMP 1'b0
`endif

// >>> rtl/csscfg_pkg.sv
// Types shared by the clock source select configuration decode
package csscfg_pkg;
   // Four-way output clock source
   typedef enum logic [1:0] {
      CSSCFG_SRC_REF = 2'h0,
      CSSCFG_SRC_PLL_A = 2'h1,
      CSSCFG_SRC_PLL_B = 2'h2,
      CSSCFG_SRC_PLL_C = 2'h3
   } csscfg_src_t;
   // Loop filter time constant choice
   typedef enum logic {
      CSSCFG_TC_SHORT = 1'b0,
      CSSCFG_TC_LONG = 1'b1
   } csscfg_tc_t;
   // Charge pump current choice
   typedef enum logic {
      CSSCFG_PUMP_LOW = 1'b0,
      CSSCFG_PUMP_HIGH = 1'b1
   } csscfg_pump_t;
endpackage : csscfg_pkg

// >>> rtl/csscfg_decode.sv
// Decode of the serially loaded control word into mux selects and PLL tuning
`timescale 1ns/1ps
`include "csscfg_regs.svh"
// Control word map as seen on the port (bit n is control bit n):
// 23:22 A mux source, 47:46 B mux source
// 71:70 C source primary, 125:124 C source alternate
// 95:94 D source primary, 127:126 D source alternate
// 20 and 44 filter time of PLL A and PLL B
// 68 and 92 filter time of PLL C, primary and alternate
// 19 and 43 pump current of PLL A and PLL B
// 67 and 91 pump current of PLL C, primary and alternate
// Divider and power-down fields live in the same word and are left to
// their own decoders, so most of the word is unread here.
// Source codes: 0 reference, 1 PLL A, 2 PLL B, 3 PLL C; all four are legal.
// The set pin swaps the C source, the D source and the C tuning as one
// group. Every output is registered on the same edge, so a pin change
// can never show a mix of primary and alternate settings downstream.
// The price is one clock of latency from word or pin to the outputs.
// The pin is taken as synchronous; a board-level switch needs an
// external synchroniser ahead of this block.
// Reset parks everything on the reference source, short filters and low pumps.
module csscfg_decode #(
   parameter int WORD_W = `CSSCFG_WORD_W
)(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WORD_W-1:0] control_word, // Word loaded by the serial interface
   input wire logic alternate_set_pin, // High picks the alternate C/D set
   output csscfg_pkg::csscfg_src_t out_a_source,
   output csscfg_pkg::csscfg_src_t out_b_source,
   output csscfg_pkg::csscfg_src_t out_c_source, // Active C source after set choice
   output csscfg_pkg::csscfg_src_t out_d_source, // Active D source after set choice
   output csscfg_pkg::csscfg_tc_t filter_time_sel_pll_a,
   output csscfg_pkg::csscfg_tc_t filter_time_sel_pll_b,
   output csscfg_pkg::csscfg_tc_t filter_time_sel_pll_c, // Active C filter setting
   output csscfg_pkg::csscfg_pump_t pump_current_pll_a,
   output csscfg_pkg::csscfg_pump_t pump_current_pll_b,
   output csscfg_pkg::csscfg_pump_t pump_current_pll_c, // Active C pump setting
   output logic alternate_set_active // Registered copy of the set choice
);
   // Raw fields pulled out of the word
   logic [1:0] out_c_primary_source;
   logic [1:0] out_c_alternate_source;
   logic [1:0] out_d_primary_source;
   logic [1:0] out_d_alternate_source;
   logic filter_time_sel_c_primary;
   logic filter_time_sel_c_alternate;
   logic pump_current_c_primary;
   logic pump_current_c_alternate;
   // Next values of the selected C/D settings
   logic [1:0] next_c_src;
   logic [1:0] next_d_src;
   logic next_c_tc;
   logic next_c_pump;

   // Field extraction; the word has no default, software loads every field first
   // The word is a level input: whatever the loader leaves is decoded as is,
   // so a half-loaded word shows through until the loader finishes.
   assign out_c_primary_source = control_word[`CSSCFG_C_PRI_SRC_HI:`CSSCFG_C_PRI_SRC_LO];
   assign out_c_alternate_source = control_word[`CSSCFG_C_ALT_SRC_HI:`CSSCFG_C_ALT_SRC_LO];
   assign out_d_primary_source = control_word[`CSSCFG_D_PRI_SRC_HI:`CSSCFG_D_PRI_SRC_LO];
   assign out_d_alternate_source = control_word[`CSSCFG_D_ALT_SRC_HI:`CSSCFG_D_ALT_SRC_LO];
   assign filter_time_sel_c_primary = control_word[`CSSCFG_FILTER_C_PRI_BIT];
   assign filter_time_sel_c_alternate = control_word[`CSSCFG_FILTER_C_ALT_BIT];
   assign pump_current_c_primary = control_word[`CSSCFG_PUMP_C_PRI_BIT];
   assign pump_current_c_alternate = control_word[`CSSCFG_PUMP_C_ALT_BIT];

   // Set choice: the pin swaps the whole C/D group together, never part of it
   always_comb
   begin
      // Both branches assign all four next values, so no latch is inferred
      if (alternate_set_pin)
      begin
         next_c_src = out_c_alternate_source;
         next_d_src = out_d_alternate_source;
         next_c_tc = filter_time_sel_c_alternate;
         next_c_pump = pump_current_c_alternate;
      end
      else
      begin
         next_c_src = out_c_primary_source;
         next_d_src = out_d_primary_source;
         next_c_tc = filter_time_sel_c_primary;
         next_c_pump = pump_current_c_primary;
      end
   end

   // Mux selects, registered so outputs are glitch free
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         // Reference until software has loaded a real word
         out_a_source <= csscfg_pkg::csscfg_src_t'(`CSSCFG_RESET_SRC);
         out_b_source <= csscfg_pkg::csscfg_src_t'(`CSSCFG_RESET_SRC);
         out_c_source <= csscfg_pkg::csscfg_src_t'(`CSSCFG_RESET_SRC);
         out_d_source <= csscfg_pkg::csscfg_src_t'(`CSSCFG_RESET_SRC);
      end
      else
      begin
         out_a_source <= csscfg_pkg::csscfg_src_t'(
            control_word[`CSSCFG_MUX_A_HI:`CSSCFG_MUX_A_LO]);
         out_b_source <= csscfg_pkg::csscfg_src_t'(
            control_word[`CSSCFG_MUX_B_HI:`CSSCFG_MUX_B_LO]);
         out_c_source <= csscfg_pkg::csscfg_src_t'(next_c_src);
         out_d_source <= csscfg_pkg::csscfg_src_t'(next_d_src);
      end
   end

   // Reset must leave every mux on the reference, whatever the word holds
   AST_RESET_SRC: assert property (@(posedge clk)
      !reset_n |=> out_a_source == csscfg_pkg::CSSCFG_SRC_REF &&
      out_b_source == csscfg_pkg::CSSCFG_SRC_REF &&
      out_c_source == csscfg_pkg::CSSCFG_SRC_REF &&
      out_d_source == csscfg_pkg::CSSCFG_SRC_REF)
      else $error("mux select not cleared by reset");

   // PLL tuning bits; reset holds the short filter and low current
   // A and B have no alternate set, only C goes through the set choice
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         filter_time_sel_pll_a <= csscfg_pkg::csscfg_tc_t'(`CSSCFG_RESET_TC);
         filter_time_sel_pll_b <= csscfg_pkg::csscfg_tc_t'(`CSSCFG_RESET_TC);
         filter_time_sel_pll_c <= csscfg_pkg::csscfg_tc_t'(`CSSCFG_RESET_TC);
         pump_current_pll_a <= csscfg_pkg::csscfg_pump_t'(`CSSCFG_RESET_PUMP);
         pump_current_pll_b <= csscfg_pkg::csscfg_pump_t'(`CSSCFG_RESET_PUMP);
         pump_current_pll_c <= csscfg_pkg::csscfg_pump_t'(`CSSCFG_RESET_PUMP);
         alternate_set_active <= 1'b0;
      end
      else
      begin
         filter_time_sel_pll_a <= csscfg_pkg::csscfg_tc_t'(
            control_word[`CSSCFG_FILTER_A_BIT]);
         filter_time_sel_pll_b <= csscfg_pkg::csscfg_tc_t'(
            control_word[`CSSCFG_FILTER_B_BIT]);
         filter_time_sel_pll_c <= csscfg_pkg::csscfg_tc_t'(next_c_tc);
         pump_current_pll_a <= csscfg_pkg::csscfg_pump_t'(
            control_word[`CSSCFG_PUMP_A_BIT]);
         pump_current_pll_b <= csscfg_pkg::csscfg_pump_t'(
            control_word[`CSSCFG_PUMP_B_BIT]);
         pump_current_pll_c <= csscfg_pkg::csscfg_pump_t'(next_c_pump);
         alternate_set_active <= alternate_set_pin;
      end
   end

   // Reset leaves short filters, low pumps and the primary set
   AST_RESET_TUNE: assert property (@(posedge clk)
      !reset_n |=> filter_time_sel_pll_a == csscfg_pkg::CSSCFG_TC_SHORT &&
      filter_time_sel_pll_b == csscfg_pkg::CSSCFG_TC_SHORT &&
      filter_time_sel_pll_c == csscfg_pkg::CSSCFG_TC_SHORT &&
      pump_current_pll_a == csscfg_pkg::CSSCFG_PUMP_LOW &&
      pump_current_pll_b == csscfg_pkg::CSSCFG_PUMP_LOW &&
      pump_current_pll_c == csscfg_pkg::CSSCFG_PUMP_LOW && !alternate_set_active)
      else $error("tuning bits not cleared by reset");

   // PLL A and B tuning bits follow their own word bits, with no set choice
   AST_TC_A: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $past(reset_n) |-> filter_time_sel_pll_a == $past(control_word[20]))
      else $error("A filter setting mismatch");
   AST_TC_B: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $past(reset_n) |-> filter_time_sel_pll_b == $past(control_word[44]))
      else $error("B filter setting mismatch");
   AST_PUMP_A: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $past(reset_n) |-> pump_current_pll_a == $past(control_word[19]))
      else $error("A pump setting mismatch");
   AST_PUMP_B: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $past(reset_n) |-> pump_current_pll_b == $past(control_word[43]))
      else $error("B pump setting mismatch");

   // Checks tying each output to its field one cycle earlier
   AST_MUX_A: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $past(reset_n) |-> out_a_source == $past(control_word[23:22]))
      else $error("mux A select mismatch");
   AST_MUX_B: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $past(reset_n) |-> out_b_source == $past(control_word[47:46]))
      else $error("mux B select mismatch");

   // C and D selects follow the pin sampled on the same edge as the word
   AST_C_PRI: assert property (@(posedge clk) disable iff (!reset_n)
      !alternate_set_pin ##1 $past(reset_n) |-> out_c_source == $past(control_word[71:70]))
      else $error("C primary select mismatch");
   AST_C_ALT: assert property (@(posedge clk) disable iff (!reset_n)
      alternate_set_pin ##1 $past(reset_n) |-> out_c_source == $past(control_word[125:124]))
      else $error("C alternate select mismatch");
   AST_D_PRI: assert property (@(posedge clk) disable iff (!reset_n)
      !alternate_set_pin ##1 $past(reset_n) |-> out_d_source == $past(control_word[95:94]))
      else $error("D primary select mismatch");
   AST_D_ALT: assert property (@(posedge clk) disable iff (!reset_n)
      alternate_set_pin ##1 $past(reset_n) |-> out_d_source == $past(control_word[127:126]))
      else $error("D alternate select mismatch");

   // C tuning follows the same set choice as the C and D selects
   AST_TC_C: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $past(reset_n) |-> filter_time_sel_pll_c ==
      $past(alternate_set_pin ? control_word[92] : control_word[68]))
      else $error("C filter setting mismatch");
   AST_PUMP_C: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $past(reset_n) |-> pump_current_pll_c ==
      $past(alternate_set_pin ? control_word[91] : control_word[67]))
      else $error("C pump setting mismatch");

   // The registered set choice is the pin, one clock late
   AST_SET: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $past(reset_n) |-> alternate_set_active == $past(alternate_set_pin))
      else $error("set choice mismatch");

   // The shown set choice and the C/D selects always belong together
   AST_C_FOLLOWS_SET: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $past(reset_n) |-> out_c_source == (alternate_set_active ?
      $past(control_word[125:124]) : $past(control_word[71:70])))
      else $error("C select does not follow the set choice");
   AST_D_FOLLOWS_SET: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $past(reset_n) |-> out_d_source == (alternate_set_active ?
      $past(control_word[127:126]) : $past(control_word[95:94])))
      else $error("D select does not follow the set choice");

   // Held inputs must give held outputs: nothing in here counts or toggles
   AST_HOLD_CD: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $past(reset_n) && $stable(control_word) && $stable(alternate_set_pin)
      |=> $stable(out_c_source) && $stable(out_d_source))
      else $error("C or D select moved under held inputs");
   AST_HOLD_TUNE: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $past(reset_n) && $stable(control_word) && $stable(alternate_set_pin)
      |=> $stable(filter_time_sel_pll_c) && $stable(pump_current_pll_c))
      else $error("C tuning moved under held inputs");
endmodule : csscfg_decode

// >>> verif/tb_top.sv
// Self-checking testbench for the clock source select decode
`timescale 1ns/1ps
module tb_top;
   logic clk; // 200 MHz clock
   logic reset_n; // Synchronous reset, active low
   logic [127:0] control_word; // Word as a serial loader would leave it
   logic alternate_set_pin; // High picks the alternate C/D set
   csscfg_pkg::csscfg_src_t src_a, src_b, src_c, src_d; // Active mux selects
   csscfg_pkg::csscfg_tc_t tc_a, tc_b, tc_c; // Filter time constant choices
   csscfg_pkg::csscfg_pump_t cp_a, cp_b, cp_c; // Pump current choices
   logic alt_active; // Registered set choice
   int err_total = 0; // Mismatches seen
   int compares = 0; // Comparisons made
   int pos [8] = '{20, 44, 68, 92, 19, 43, 67, 91}; // Tuning bit positions
   logic [7:0] e; // One-hot expectation for the tuning walk

   csscfg_decode uut (.clk(clk), .reset_n(reset_n), .control_word(control_word),
      .alternate_set_pin(alternate_set_pin), .out_a_source(src_a), .out_b_source(src_b),
      .out_c_source(src_c), .out_d_source(src_d), .filter_time_sel_pll_a(tc_a),
      .filter_time_sel_pll_b(tc_b), .filter_time_sel_pll_c(tc_c), .pump_current_pll_a(cp_a),
      .pump_current_pll_b(cp_b), .pump_current_pll_c(cp_c), .alternate_set_active(alt_active));

   // Free-running clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Compare with case equality so an unknown never passes
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // Drive on the falling edge; outputs are settled one full cycle later
   task automatic apply(input logic [127:0] w, input logic pin);
      @(negedge clk);
      control_word = w;
      alternate_set_pin = pin;
      @(negedge clk);
   endtask : apply

   // Print counts and verdict, then stop
   task automatic give_verdict();
      $display("counts: %0d compares, %0d mismatches", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   // Reset forces zero outputs even with all-ones inputs, also mid-run
   task automatic test_reset();
      check({src_a, src_b, src_c, src_d}, 8'h00, "src in reset");
      check({tc_a, tc_b, tc_c, cp_a, cp_b, cp_c, alt_active}, 8'h00, "tune in reset");
      @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      check({src_c, src_d, tc_c, cp_c, alt_active}, 8'h7f, "first load");
      check({src_a, src_b, tc_a, tc_b, cp_a, cp_b}, 8'hff, "first load a b");
      reset_n = 1'b0;
      @(negedge clk);
      check({src_a, src_b, src_c, src_d}, 8'h00, "mid-run reset");
      check({tc_a, tc_b, tc_c, cp_a, cp_b, cp_c, alt_active}, 8'h00, "mid-run tune reset");
      reset_n = 1'b1;
      $display("test_reset done");
   endtask : test_reset

   // Every source code on every selector, both sets, back to back
   task automatic test_sources();
      logic [127:0] w;
      logic [1:0] v;
      logic [1:0] exp_c; // Two-bit expectation, so the sums wrap as the field does
      logic [1:0] exp_d;
      for (int i = 0; i < 8; i++)
      begin
         v = i[1:0];
         w = '0;
         w[23:22] = v;
         w[47:46] = v + 2'h1;
         w[71:70] = v + 2'h2;
         w[125:124] = v + 2'h3;
         w[95:94] = ~v;
         w[127:126] = ~v + 2'h1;
         apply(w, i[2]);
         check({src_a, src_b}, {v, v + 2'h1}, "a b source");
         exp_c = i[2] ? v + 2'h3 : v + 2'h2;
         exp_d = i[2] ? ~v + 2'h1 : ~v;
         check(src_c, exp_c, "c source");
         check(src_d, exp_d, "d source");
         check(alt_active, i[2], "set choice");
      end
      $display("test_sources done");
   endtask : test_sources

   // Walk one tuning bit at a time under both set choices
   task automatic test_tuning();
      for (int i = 0; i < 16; i++)
      begin
         e = 8'h01 << i[2:0];
         apply(128'h1 << pos[i[2:0]], i[3]);
         check({tc_a, tc_b}, {e[0], e[1]}, "filter a b");
         check(tc_c, i[3] ? e[3] : e[2], "filter c");
         check({cp_a, cp_b}, {e[4], e[5]}, "pump a b");
         check(cp_c, i[3] ? e[7] : e[6], "pump c");
      end
      $display("test_tuning done");
   endtask : test_tuning

   // Main sequence: inputs are all ones while reset is held for 20 cycles
   initial
   begin
      reset_n = 1'b0;
      control_word = '1;
      alternate_set_pin = 1'b1;
      repeat (20) @(negedge clk);
      test_reset();
      test_sources();
      test_tuning();
      give_verdict();
   end

   // Watchdog: the tests need well under 200 cycles
   initial
   begin
      repeat (2000) @(posedge clk);
      err_total++;
      give_verdict();
   end
endmodule : tb_top
